// ===== hw/pll_reconfig_pkg.sv
// Shared constants for the synthesiser scan reconfiguration ends
package pll_reconfig_pkg;
  // ==========================================================
  // Scan chain layout
  localparam int CHAIN_BITS  = 144;
  localparam int DIV_BITS    = 18;
  localparam int NUM_DIV     = 7;
  localparam int NUM_OUT     = 5;
  localparam int FB_IDX      = 5;
  localparam int PRE_IDX     = 6;
  localparam int NUM_TAP_DIV = 6;
  localparam int CNT_W       = 8;
  localparam int LOW_LSB     = 0;
  localparam int HIGH_LSB    = 8;
  localparam int ODD_BIT     = 16;
  localparam int SKIP_BIT    = 17;
  localparam int PUMP_LSB    = 126;
  localparam int PUMP_W      = 9;
  localparam int FILT_LSB    = 135;
  localparam int FILT_W      = 9;
  localparam logic [DIV_BITS-1:0] DIV_RESET_CFG = 18'h20000;
  localparam logic [PUMP_W-1:0]   PUMP_RESET    = 9'h000;
  localparam logic [FILT_W-1:0]   FILT_RESET    = 9'h000;

  // ==========================================================
  // Oscillator model and phase stepping
  localparam int TAP_W = 3;
  localparam logic [TAP_W-1:0] HALF_TAP  = 3'h4;
  localparam logic [TAP_W-1:0] SEL_ALL_C = 3'h7;

  // ==========================================================
  // Timing
  localparam int PCLK_HZ        = 25_000_000;
  localparam int PCLK_PERIOD_NS = 40;
  localparam int SCAN_MAX_HZ    = 100_000_000;
  localparam int SCAN_HALF_RAW  =
    (PCLK_HZ + 2 * SCAN_MAX_HZ - 1) / (2 * SCAN_MAX_HZ);
  localparam int SCAN_HALF = (SCAN_HALF_RAW < 1) ? 1 : SCAN_HALF_RAW;
  localparam int HALF_W    = 4;
  localparam int LOOP_RESET_NS  = 10;
  localparam int LOOP_RESET_RAW =
    (LOOP_RESET_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
  localparam int LOOP_RESET_CYC =
    (LOOP_RESET_RAW < 1) ? 1 : LOOP_RESET_RAW;

  // ==========================================================
  // Controller register map
  localparam int ADDR_W    = 8;
  localparam int WORD_W    = 32;
  localparam int IMG_WORDS = 5;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] IMG_OFS  = 8'h10;
  localparam logic [ADDR_W-1:0] IMG_END  = 8'h24;
  localparam int CTRL_START = 0;
  localparam int CTRL_RST   = 1;
  localparam int CTRL_STEP  = 2;
  localparam int CTRL_UP    = 3;
  localparam int CTRL_SEL   = 4;
  localparam int STAT_BUSY  = 0;
  localparam int STAT_DONE  = 1;
  localparam int STAT_PEND  = 2;
endpackage : pll_reconfig_pkg

// ===== hw/pll_link_if.sv
// Link between the reconfiguration controller and the synthesiser
`timescale 1ns/1ns
interface pll_link_if;
  logic       scan_clk;
  logic       scan_gate;
  logic       scan_data;
  logic       commit;
  logic       done;
  logic       loop_reset;
  logic       phase_step;
  logic       phase_up;
  logic [2:0] phase_sel;

  modport device (
    input  scan_clk, scan_gate, scan_data, commit, loop_reset,
    input  phase_step, phase_up, phase_sel,
    output done
  );
  modport ctrl (
    output scan_clk, scan_gate, scan_data, commit, loop_reset,
    output phase_step, phase_up, phase_sel,
    input  done
  );
endinterface : pll_link_if

// ===== hw/pll_post_div.sv
// One high/low time divider with skip, odd, tap and start delay
`timescale 1ns/1ns
module pll_post_div
  import pll_reconfig_pkg::*;
(
  // Clock, reset and enable
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                ce,
  // Oscillator phase and control
  input  wire logic                restart,
  input  wire logic [TAP_W-1:0]    vco_phase,
  input  wire logic [TAP_W-1:0]    tap,
  input  wire logic [CNT_W-1:0]    start_count,
  // New setting handshake
  input  wire logic [DIV_BITS-1:0] cfg_new,
  input  wire logic                load_req,
  output logic                     taken,
  // Divided clock
  output logic                     out_clk
);
  logic [DIV_BITS-1:0] cfg_reg, cfg_next;
  logic [CNT_W:0]      cnt_reg, cnt_next;
  logic [CNT_W-1:0]    dly_reg, dly_next;
  logic                run_reg, run_next;
  logic                out_reg, out_next;
  logic                taken_reg, taken_next;
  logic [TAP_W-1:0]    rel;
  logic [CNT_W-1:0]    hi_n;
  logic [CNT_W:0]      total_n;
  logic                skip_n;

  // ==========================================================
  // Counting
  always_comb begin
    rel        = vco_phase - tap;
    cfg_next   = cfg_reg;
    cnt_next   = cnt_reg;
    dly_next   = dly_reg;
    run_next   = run_reg;
    taken_next = 1'b0;
    if (restart) begin
      cnt_next = '0;
      run_next = 1'b0;
      dly_next = (start_count == '0) ? '0 : start_count - 1'b1;
    end else if (rel == '0) begin
      if (!run_reg) begin
        if (dly_reg == '0) run_next = 1'b1;
        else dly_next = dly_reg - 1'b1;
      end else if (cfg_reg[SKIP_BIT] ||
                   cnt_reg == {1'b0, cfg_reg[HIGH_LSB +: CNT_W]}
                   + {1'b0, cfg_reg[LOW_LSB +: CNT_W]} - 1'b1) begin
        cnt_next = '0;
        // New setting only at this divider's own period end
        if (load_req) begin
          cfg_next   = cfg_new;
          taken_next = 1'b1;
        end
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
    hi_n    = cfg_next[HIGH_LSB +: CNT_W];
    total_n = {1'b0, hi_n} + {1'b0, cfg_next[LOW_LSB +: CNT_W]};
    skip_n  = cfg_next[SKIP_BIT] || total_n == '0;
    if (!run_next)
      out_next = 1'b0;
    else if (skip_n)
      out_next = rel < HALF_TAP;
    else if (cfg_next[ODD_BIT] && cnt_next == {1'b0, hi_n} - 1'b1)
      out_next = rel < HALF_TAP;
    else
      out_next = cnt_next < {1'b0, hi_n};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg   <= DIV_RESET_CFG;
      cnt_reg   <= '0;
      dly_reg   <= '0;
      run_reg   <= 1'b0;
      out_reg   <= 1'b0;
      taken_reg <= 1'b0;
    end else if (ce) begin
      cfg_reg   <= cfg_next;
      cnt_reg   <= cnt_next;
      dly_reg   <= dly_next;
      run_reg   <= run_next;
      out_reg   <= out_next;
      taken_reg <= taken_next;
    end
  end

  assign out_clk = out_reg;
  assign taken   = taken_reg;
endmodule : pll_post_div

// ===== hw/pll_scan_device.sv
// Synthesiser end: scan chain, commit handshake, divider bank
`timescale 1ns/1ns

// Summary of operation
// - Bits shift in on scan clock, 100 MHz max
// - Commit copies chain into active settings
// - Each divider switches on its own clock
// - Gate rises one scan cycle before D0
// - First bit taken on second rising edge
// - Gate dropped after exactly 144 bits
// - Done high from commit until dividers loaded
// - Pulse loop reset after divider or loop change
// - No new sequence until done falls
// - Redo phase steps after frequency change
// - Eight-bit high and low VCO counts
// - Skip bit gives divide by one
// - Normal output falls on VCO rising edge
// - Odd select falls half cycle earlier
// - Each divider except the prescaler picks one of eight taps
// - Start delayed by initial count minus one
// - Phase steps move tap, one scan cycle
// - All dividers and loop settings reloadable
// - Cascade: upstream low, downstream high bandwidth
// - Eighteen bits per divider, last C first
module pll_scan_device
  import pll_reconfig_pkg::*;
(
  // Clock, reset and enable
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          ce,
  // Link to the controller
  pll_link_if.device                         link,
  // Coarse start count of each divider
  input  wire logic [NUM_DIV-1:0][CNT_W-1:0] start_count,
  // Synthesised clocks
  output logic [NUM_OUT-1:0]                 out_clk,
  output logic                               fb_clk,
  output logic                               pre_clk,
  // Loop settings
  output logic [PUMP_W-1:0]                  pump_current,
  output logic [FILT_W-1:0]                  loop_filter
);
  logic [CHAIN_BITS-1:0]             chain_reg, chain_next;
  logic                              sclk_prev_reg, sclk_prev_next;
  logic                              armed_reg, armed_next;
  logic                              step_prev_reg, step_prev_next;
  logic                              restart_reg, restart_next;
  logic [NUM_DIV-1:0]                load_reg, load_next;
  logic                              done_reg, done_next;
  logic [PUMP_W-1:0]                 pump_reg, pump_next;
  logic [FILT_W-1:0]                 filt_reg, filt_next;
  logic [TAP_W-1:0]                  vco_reg, vco_next;
  logic [NUM_TAP_DIV-1:0][TAP_W-1:0] tap_reg, tap_next;
  logic [NUM_DIV-1:0]                taken;
  logic [NUM_DIV-1:0]                div_clk;
  logic                              rise;
  logic                              commit_now;

  // ==========================================================
  // Scan chain, commit and phase steps
  always_comb begin
    rise           = link.scan_clk && !sclk_prev_reg;
    commit_now     = rise && link.commit;
    sclk_prev_next = link.scan_clk;
    chain_next     = chain_reg;
    armed_next     = armed_reg;
    step_prev_next = step_prev_reg;
    pump_next      = pump_reg;
    filt_next      = filt_reg;
    tap_next       = tap_reg;
    restart_next   = link.loop_reset;
    vco_next       = vco_reg + 1'b1;
    if (rise) begin
      // First edge with the gate up only arms the chain
      armed_next = link.scan_gate;
      if (link.scan_gate && armed_reg)
        chain_next = {link.scan_data, chain_reg[CHAIN_BITS-1:1]};
      step_prev_next = link.phase_step;
      if (link.phase_step && !step_prev_reg) begin
        for (int i = 0; i < NUM_TAP_DIV; i++) begin
          if (link.phase_sel == TAP_W'(i) ||
              (link.phase_sel == SEL_ALL_C && i < NUM_OUT))
            tap_next[i] = link.phase_up ? tap_reg[i] + 1'b1
                                        : tap_reg[i] - 1'b1;
        end
      end
    end
    if (commit_now) begin
      pump_next = chain_reg[PUMP_LSB +: PUMP_W];
      filt_next = chain_reg[FILT_LSB +: FILT_W];
    end
    // A fresh commit wins over a divider finishing in the same cycle
    load_next = load_reg & ~taken;
    if (commit_now)
      load_next = '1;
    if (commit_now)
      done_next = 1'b1;
    else if (load_next == '0)
      done_next = 1'b0;
    else
      done_next = done_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_reg     <= '0;
      sclk_prev_reg <= 1'b0;
      armed_reg     <= 1'b0;
      step_prev_reg <= 1'b0;
      restart_reg   <= 1'b0;
      load_reg      <= '0;
      done_reg      <= 1'b0;
      pump_reg      <= PUMP_RESET;
      filt_reg      <= FILT_RESET;
      vco_reg       <= '0;
      tap_reg       <= '0;
    end else if (ce) begin
      chain_reg     <= chain_next;
      sclk_prev_reg <= sclk_prev_next;
      armed_reg     <= armed_next;
      step_prev_reg <= step_prev_next;
      restart_reg   <= restart_next;
      load_reg      <= load_next;
      done_reg      <= done_next;
      pump_reg      <= pump_next;
      filt_reg      <= filt_next;
      vco_reg       <= vco_next;
      tap_reg       <= tap_next;
    end
  end

  // ==========================================================
  // Divider bank: outputs in reverse order, then feedback, prescale
  for (genvar i = 0; i < NUM_DIV; i++) begin : g_div
    localparam int LSB = (i < NUM_OUT) ? (NUM_OUT - 1 - i) * DIV_BITS
                                       : i * DIV_BITS;
    logic [TAP_W-1:0] tap_sel;
    if (i < NUM_TAP_DIV) begin : g_tap
      assign tap_sel = tap_reg[i];
    end else begin : g_notap
      assign tap_sel = '0;
    end
    pll_post_div u_div (
      .pclk        (pclk),
      .presetn     (presetn),
      .ce          (ce),
      .restart     (restart_reg),
      .vco_phase   (vco_reg),
      .tap         (tap_sel),
      .start_count (start_count[i]),
      .cfg_new     (chain_reg[LSB +: DIV_BITS]),
      .load_req    (load_reg[i]),
      .taken       (taken[i]),
      .out_clk     (div_clk[i])
    );
  end

  assign out_clk      = div_clk[NUM_OUT-1:0];
  assign fb_clk       = div_clk[FB_IDX];
  assign pre_clk      = div_clk[PRE_IDX];
  assign pump_current = pump_reg;
  assign loop_filter  = filt_reg;
  assign link.done    = done_reg;
endmodule : pll_scan_device

// ===== hw/pll_scan_ctrl.sv
// Fabric-side reconfiguration controller with an APB register port
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
module pll_scan_ctrl
  import pll_reconfig_pkg::*;
(
  // Clock, reset and enable
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [WORD_W-1:0] pwdata,
  output logic      [WORD_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Link to the synthesiser
  pll_link_if.ctrl               link
);
  typedef enum logic [3:0] {
    S_IDLE, S_SHIFT, S_STOP, S_COMMIT, S_WAIT_HI, S_WAIT_LO,
    S_RESET, S_STEP
  } state_e;

  localparam int IMG_BITS = IMG_WORDS * WORD_W;

  state_e                state_reg, state_next;
  logic [IMG_BITS-1:0]   img_reg, img_next;
  logic [WORD_W-1:0]     prdata_reg, prdata_next;
  logic                  pready_reg, pready_next;
  logic                  err_reg, err_next;
  logic                  go_reg, go_next;
  logic                  stepq_reg, stepq_next;
  logic                  rst_after_reg, rst_after_next;
  logic                  up_reg, up_next;
  logic [TAP_W-1:0]      sel_reg, sel_next;
  logic [HALF_W-1:0]     half_reg, half_next;
  logic                  sclk_reg, sclk_next;
  logic                  gate_reg, gate_next;
  logic                  data_reg, data_next;
  logic                  commit_reg, commit_next;
  logic                  step_reg, step_next;
  logic                  areset_reg, areset_next;
  logic                  hold_reg, hold_next;
  logic [7:0]            bit_reg, bit_next;
  logic [HALF_W-1:0]     rcnt_reg, rcnt_next;
  logic                  fall;
  logic                  busy;
  logic [2:0]            widx;

  always_comb begin
    // ========================================================
    // Scan clock: half period never below the 100 MHz bound
    fall      = half_reg == HALF_W'(SCAN_HALF - 1) && sclk_reg;
    half_next = (half_reg == HALF_W'(SCAN_HALF - 1)) ? '0
                                                   : half_reg + 1'b1;
    sclk_next = (half_reg == HALF_W'(SCAN_HALF - 1)) ? !sclk_reg
                                                   : sclk_reg;
    busy      = state_reg != S_IDLE;
    widx      = 3'((paddr - IMG_OFS) >> 2);

    // ========================================================
    // APB: setup cycle decodes, access cycle completes
    img_next       = img_reg;
    prdata_next    = prdata_reg;
    err_next       = err_reg;
    pready_next    = 1'b0;
    go_next        = go_reg;
    stepq_next     = stepq_reg;
    rst_after_next = rst_after_reg;
    up_next        = up_reg;
    sel_next       = sel_reg;
    if (psel && !penable && !pready_reg) begin
      pready_next = 1'b1;
      err_next    = 1'b0;
      prdata_next = '0;
      if (paddr == CTRL_OFS) begin
        prdata_next[CTRL_RST]            = rst_after_reg;
        prdata_next[CTRL_UP]             = up_reg;
        prdata_next[CTRL_SEL +: TAP_W]   = sel_reg;
      end else if (paddr == STAT_OFS) begin
        prdata_next[STAT_BUSY] = busy;
        prdata_next[STAT_DONE] = link.done;
        prdata_next[STAT_PEND] = go_reg || stepq_reg;
      end else if (paddr >= IMG_OFS && paddr < IMG_END &&
                   paddr[1:0] == 2'h0) begin
        prdata_next = img_reg[WORD_W*widx +: WORD_W];
      end else begin
        err_next = 1'b1;
      end
    end else if (psel && penable && pready_reg && pwrite && !err_reg) begin
      if (paddr == CTRL_OFS) begin
        rst_after_next = pwdata[CTRL_RST];
        up_next        = pwdata[CTRL_UP];
        sel_next       = pwdata[CTRL_SEL +: TAP_W];
        // Starts while busy are dropped
        if (pwdata[CTRL_START] && !busy) go_next = 1'b1;
        if (pwdata[CTRL_STEP] && !busy) stepq_next = 1'b1;
      end else if (paddr >= IMG_OFS && !busy) begin
        img_next[WORD_W*widx +: WORD_W] = pwdata;
      end
    end

    // ========================================================
    // Sequencer: gate, data, commit and step change only on scan clock falls
    state_next  = state_reg;
    gate_next   = gate_reg;
    data_next   = data_reg;
    commit_next = commit_reg;
    step_next   = step_reg;
    areset_next = areset_reg;
    hold_next   = hold_reg;
    bit_next    = bit_reg;
    rcnt_next   = rcnt_reg;
    case (state_reg)
      S_IDLE: begin
        if (fall && go_reg) begin
          gate_next  = 1'b1;
          data_next  = img_reg[0];
          bit_next   = '0;
          hold_next  = 1'b1;
          go_next    = 1'b0;
          state_next = S_SHIFT;
        end else if (fall && stepq_reg) begin
          step_next  = 1'b1;
          stepq_next = 1'b0;
          state_next = S_STEP;
        end
      end
      S_SHIFT: begin
        if (fall) begin
          if (hold_reg) begin
            hold_next = 1'b0;
          end else if (bit_reg == 8'(CHAIN_BITS - 1)) begin
            gate_next  = 1'b0;
            state_next = S_STOP;
          end else begin
            bit_next  = bit_reg + 1'b1;
            data_next = img_reg[bit_reg + 1'b1];
          end
        end
      end
      S_STOP: begin
        if (fall) begin
          commit_next = 1'b1;
          state_next  = S_COMMIT;
        end
      end
      S_COMMIT: begin
        if (fall) begin
          commit_next = 1'b0;
          state_next  = S_WAIT_HI;
        end
      end
      S_WAIT_HI: if (link.done) state_next = S_WAIT_LO;
      S_WAIT_LO: begin
        if (!link.done) begin
          if (rst_after_reg) begin
            areset_next = 1'b1;
            rcnt_next   = '0;
            state_next  = S_RESET;
          end else begin
            state_next = S_IDLE;
          end
        end
      end
      S_RESET: begin
        rcnt_next = rcnt_reg + 1'b1;
        if (rcnt_reg == HALF_W'(LOOP_RESET_CYC - 1)) begin
          areset_next = 1'b0;
          state_next  = S_IDLE;
        end
      end
      S_STEP: begin
        if (fall) begin
          step_next  = 1'b0;
          state_next = S_IDLE;
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= S_IDLE;
      img_reg       <= '0;
      prdata_reg    <= '0;
      pready_reg    <= 1'b0;
      err_reg       <= 1'b0;
      go_reg        <= 1'b0;
      stepq_reg     <= 1'b0;
      rst_after_reg <= 1'b0;
      up_reg        <= 1'b0;
      sel_reg       <= '0;
      half_reg      <= '0;
      sclk_reg      <= 1'b0;
      gate_reg      <= 1'b0;
      data_reg      <= 1'b0;
      commit_reg    <= 1'b0;
      step_reg      <= 1'b0;
      areset_reg    <= 1'b0;
      hold_reg      <= 1'b0;
      bit_reg       <= '0;
      rcnt_reg      <= '0;
    end else if (ce) begin
      state_reg     <= state_next;
      img_reg       <= img_next;
      prdata_reg    <= prdata_next;
      pready_reg    <= pready_next;
      err_reg       <= err_next;
      go_reg        <= go_next;
      stepq_reg     <= stepq_next;
      rst_after_reg <= rst_after_next;
      up_reg        <= up_next;
      sel_reg       <= sel_next;
      half_reg      <= half_next;
      sclk_reg      <= sclk_next;
      gate_reg      <= gate_next;
      data_reg      <= data_next;
      commit_reg    <= commit_next;
      step_reg      <= step_next;
      areset_reg    <= areset_next;
      hold_reg      <= hold_next;
      bit_reg       <= bit_next;
      rcnt_reg      <= rcnt_next;
    end
  end

  assign prdata          = prdata_reg;
  assign pready          = pready_reg;
  assign pslverr         = pready_reg && err_reg;
  assign link.scan_clk   = sclk_reg;
  assign link.scan_gate  = gate_reg;
  assign link.scan_data  = data_reg;
  assign link.commit     = commit_reg;
  assign link.loop_reset = areset_reg;
  assign link.phase_step = step_reg;
  assign link.phase_up   = up_reg;
  assign link.phase_sel  = sel_reg;
endmodule : pll_scan_ctrl

// ===== sim/pll_link_sva.sv
// Protocol checks on the link between the two ends
`timescale 1ns/1ns
module pll_link_sva (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link signals
  input wire logic scan_clk,
  input wire logic scan_gate,
  input wire logic scan_data,
  input wire logic commit,
  input wire logic done,
  input wire logic loop_reset,
  input wire logic phase_step
);
  // ======
  // Gate span: 145 scan periods of two pclk each
  logic [8:0] gcnt_reg, gcnt_next;
  always_comb gcnt_next = scan_gate ? gcnt_reg + 9'h001 : 9'h000;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) gcnt_reg <= 9'h000;
    else gcnt_reg <= gcnt_next;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_pulse2(logic s);
    s[*2] ##1 !s;
  endsequence
  sequence s_rise;
    scan_clk && !$past(scan_clk);
  endsequence
  // ======
  // Assertions
  AST_SCAN_RATE: assert property (scan_clk |=> !scan_clk)
    else $error("scan clock too slow or stuck");
  AST_FALL_ONLY: assert property (($changed(scan_data) ||
    $changed(scan_gate) || $changed(commit)) |-> $fell(scan_clk))
    else $error("link changed off a scan clock fall");
  AST_GATE_LEN: assert property ($fell(scan_gate) |-> gcnt_reg == 9'h122)
    else $error("gate span wrong");
  AST_COMMIT_LEN: assert property ($rose(commit) |-> s_pulse2(commit))
    else $error("commit not one scan period");
  AST_COMMIT_POS: assert property ($rose(commit) |->
    $past(scan_gate, 3) && !scan_gate) else $error("commit misplaced");
  AST_DONE_RISE: assert property (s_rise ##0 commit |=> done)
    else $error("done did not rise");
  AST_DONE_FALL: assert property ($rose(done) |-> ##[1:1000] !done)
    else $error("done stuck high");
  AST_NO_REGATE: assert property ($rose(scan_gate) |-> !done)
    else $error("shift began while loading");
  AST_STEP_LEN: assert property ($rose(phase_step) |-> s_pulse2(phase_step))
    else $error("phase step not one scan period");
  AST_LOOP_RST: assert property ($rose(loop_reset) |-> !done ##1
    !loop_reset) else $error("loop reset misplaced");
endmodule : pll_link_sva

// ===== sim/pll_scan_reconfig_tb_top.sv
// Bench joining controller and synthesiser ends
`timescale 1ns/1ns
module pll_scan_reconfig_tb_top;
  import pll_reconfig_pkg::*;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0]  paddr = 8'h00;
  logic [WORD_W-1:0]  pwdata = 32'h0, prdata, r;
  logic               pready, pslverr, e;
  logic [NUM_OUT-1:0] out_clk;
  logic [PUMP_W-1:0]  pump_current;
  logic [FILT_W-1:0]  loop_filter;
  logic [159:0]       img = '0;
  int seed = 32'hd359, n_fail = 0, tests_run = 0, n;
  pll_link_if link();
  pll_scan_ctrl pll_scan_ctrl_i (.pclk, .presetn, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link);
  pll_scan_device pll_scan_device_i (.pclk, .presetn, .ce, .link,
    .start_count({NUM_DIV{8'h01}}), .out_clk, .fb_clk(), .pre_clk(),
    .pump_current, .loop_filter);
  pll_link_sva pll_link_sva_i (.pclk, .presetn, .scan_clk(link.scan_clk),
    .scan_gate(link.scan_gate), .scan_data(link.scan_data),
    .commit(link.commit), .done(link.done), .loop_reset(link.loop_reset),
    .phase_step(link.phase_step));
  always #20 pclk = ~pclk;
  // ======
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] s, x);
    tests_run++;
    if (s !== x) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, x, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
    int k;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do @(posedge pclk); while (pready !== 1 && ++k < 50);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  // VCO is 8 pclk; skip passes it through, odd ends high half a cycle early
  function automatic int eper(logic [17:0] c);
    return (c[17] || c[15:0] == 0) ? 8 : 8 * (c[15:8] + c[7:0]);
  endfunction : eper
  function automatic int ehi(logic [17:0] c);
    return (c[17] || c[15:0] == 0) ? 4 : 8 * c[15:8] - (c[16] ? 4 : 0);
  endfunction : ehi
  task automatic meas(input int k, input logic [17:0] c);
    int r1, r2, f;
    logic p;
    r1 = -1;
    r2 = -1;
    f = -1;
    p = 1;
    for (int i = 0; i < 600; i++) begin
      @(posedge pclk);
      if (out_clk[k] && !p) begin
        if (r1 < 0) r1 = i;
        else if (r2 < 0) r2 = i;
      end
      if (!out_clk[k] && p && r1 >= 0 && f < 0) f = i;
      p = out_clk[k];
    end
    chk("period", r2 - r1, eper(c));
    chk("high", f - r1, ehi(c));
  endtask : meas
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  initial begin
    #2400000;
    n_fail++;
    complete_run;
  end
  // ======
  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, STAT_OFS, 0);
    chk("stat", r, 0);
    apb(0, 8'h08, 0);
    chk("slverr", e, 1);
    for (int t = 0; t < 3; t++) begin
      for (int d = 0; d < NUM_DIV; d++)
        img[d*18 +: 18] = 18'(($random(seed) & 18'h10303) | 18'h00101
          | (d > 4 ? 18'h20000 : 18'h0));
      if (t == 0) img[0 +: 36] = {18'h10201, 18'h20000};
      img[126 +: 18] = 18'($random(seed));
      for (int w = 0; w < IMG_WORDS; w++)
        apb(1, IMG_OFS + 8'(4 * w), img[w*32 +: 32]);
      apb(1, CTRL_OFS, 32'h3);
      n = 0;
      do apb(0, STAT_OFS, 0); while ((r & 32'h5) !== 0 && ++n < 400);
      chk("pump", pump_current, img[126 +: 9]);
      chk("filter", loop_filter, img[135 +: 9]);
      for (int k = 0; k < NUM_OUT; k++)
        meas(k, img[(4 - k)*18 +: 18]);
      $display("test %0d done", t);
    end
    apb(1, CTRL_OFS, 32'h7c);
    apb(0, CTRL_OFS, 0);
    chk("ctrl", r, 32'h78);
    repeat (4) @(posedge pclk);
    complete_run;
  end
endmodule : pll_scan_reconfig_tb_top
